// ### sim/gpshc_host_ctrl_asserts.sv
// Purpose: Port-level checks of the host command block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound from the bench top.
`timescale 1ns/100ps
`default_nettype none
module gpshc_host_ctrl_asserts import gpshc_pkg::*; (
	input wire logic core_clk_i, rst_b_i, rx_valid_i, rx_last_i, rx_fmt_bad_i, rx_server_i,
	input wire logic host_ack_i, host_nack_i, up_send_i, up_server_i, tx_taken_i,
	input wire logic up_ready_o, tx_req_o, tx_resend_o, cmd_exec_o,
	input wire gpshc_tx_e tx_kind_o,
	input wire gpshc_err_e tx_err_o,
	input wire logic [7:0] command_identifier_o,
	input wire logic [2:0] baud_code_o,
	input wire logic [PRM_W-1:0] ref_freq_o,
	input wire logic [DOP_W-1:0] doppler_range_o
);
	logic srv_pend_reg, srv_pend_next, bad_end;
	assign bad_end = rx_valid_i && rx_last_i && rx_fmt_bad_i;
	// Server uplink awaiting ACK
	always_comb begin
		srv_pend_next = srv_pend_reg;
		if (host_ack_i) srv_pend_next = 1'b0;
		else if (up_send_i && up_ready_o && up_server_i) srv_pend_next = 1'b1;
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) srv_pend_reg <= 1'b0;
		else srv_pend_reg <= srv_pend_next;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_init; $rose(rst_b_i) |-> ref_freq_o == REF_FREQ_INIT && doppler_range_o == DOPPLER_INIT; endproperty
	a_init: assert property (p_init) else $error("power-on values wrong");
	property p_rst_cmd; cmd_exec_o && command_identifier_o == CMD_RESET |-> $stable(baud_code_o) && ref_freq_o == REF_FREQ_INIT; endproperty
	a_rst_cmd: assert property (p_rst_cmd) else $error("reset command wrong");
	property p_err_type; tx_req_o && tx_kind_o == TX_ERR |-> tx_err_o != ERR_NONE; endproperty
	a_err_type: assert property (p_err_type) else $error("error status without type");
	property p_req_hold; tx_req_o && !tx_taken_i |=> tx_req_o; endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped early");
	property p_up_take; up_send_i && up_ready_o |=> !up_ready_o; endproperty
	a_up_take: assert property (p_up_take) else $error("ready after uplink take");
	property p_srv_hold; srv_pend_reg |-> !up_ready_o; endproperty
	a_srv_hold: assert property (p_srv_hold) else $error("ready before host ACK");
	property p_resend; srv_pend_reg && host_nack_i |-> ##[1:8] tx_req_o && tx_resend_o; endproperty
	a_resend: assert property (p_resend) else $error("no resend after NACK");
	property p_fmt_srv; bad_end && rx_server_i |-> ##[2:12] tx_req_o && tx_kind_o == TX_NACK; endproperty
	a_fmt_srv: assert property (p_fmt_srv) else $error("no NACK for bad command");
	property p_fmt_loc; bad_end && !rx_server_i |-> ##[2:12] tx_req_o && tx_kind_o == TX_ERR && tx_err_o == ERR_FORMAT; endproperty
	a_fmt_loc: assert property (p_fmt_loc) else $error("no format error status");
	property p_fmt_drop; bad_end |=> !cmd_exec_o; endproperty
	a_fmt_drop: assert property (p_fmt_drop) else $error("bad command executed");
	c_resend: cover property (tx_req_o && tx_resend_o);
	c_tmo: cover property (tx_req_o && tx_kind_o == TX_ERR && tx_err_o == ERR_TIMEOUT);
	c_rst: cover property (cmd_exec_o && command_identifier_o == CMD_RESET);
endmodule : gpshc_host_ctrl_asserts
`default_nettype wire

// ### sim/gpshc_host_ctrl_tb.sv
// Purpose: Self-checking bench of the host command block.
// Assumes: Millisecond prescaler shortened to 4 cycles.
// Notes:   Host model answers transmit requests.
`timescale 1ns/100ps
`default_nettype none
module gpshc_host_ctrl_tb import gpshc_pkg::*;;
	logic core_clk_i, rst_b_i, rx_valid_i, rx_last_i, rx_fmt_bad_i, rx_server_i, up_send_i, up_server_i;
	logic pos_start_i, pos_sat_done_i, pos_fix_done_i, slow, nack, s, tx_taken_i, host_ack_i, host_nack_i;
	logic up_ready_o, tx_req_o, tx_resend_o, cmd_exec_o, rf_power_o, frequency_calibration_o;
	logic transmit_activity_ctrl_o, sleep_mode_o;
	gpshc_tx_e tx_kind_o, k_seen;
	gpshc_err_e tx_err_o, e_seen;
	logic [7:0] rx_byte_i, pos_sat_total_i, n_seen, n_last, command_identifier_o, extension_identifier_o;
	logic [7:0] power_save_o, flow_point_o, sat_done_o, sat_total_o, fix_count_o, fix_total_o;
	logic [2:0] baud_code_o;
	logic [23:0] ref_freq_o, sleep_timer_o, char_timeout_o, d;
	logic [15:0] doppler_range_o;
	int err_count, samples_checked;
	gpshc_host_ctrl #(.MS_CYCLES(4), .FLOW_W(8)) gpshc_host_ctrl_i (.*);
	gpshc_host_model gpshc_host_model_i (.*, .slow_i(slow), .nack_i(nack), .seen_kind_o(k_seen),
		.seen_err_o(e_seen), .seen_n_o(n_seen));
	task report_and_stop;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [23:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#5;
	endtask : cyc
	// Five-byte packet, data MSB first
	task pkt(input logic [7:0] c, e, input logic [23:0] v, input logic sv, f);
		logic [7:0] b [5];
		b = '{c, e, v[23:16], v[15:8], v[7:0]};
		for (int k = 0; k < 5; k++) begin
			cyc(1);
			{rx_valid_i, rx_byte_i, rx_last_i, rx_fmt_bad_i, rx_server_i} = {1'b1, b[k], k == 4, f, sv};
		end
		cyc(1);
		{rx_valid_i, rx_last_i} = 2'b00;
		cyc(2);
	endtask : pkt
	// Bounded wait for the next take
	task wtx(input gpshc_tx_e k, input gpshc_err_e e);
		int t;
		t = 0;
		while (n_seen === n_last && t < 80) begin
			cyc(1);
			t++;
		end
		chk("tx_count", n_last + 8'h01, n_seen);
		chk("tx_kind", k, k_seen);
		if (k == TX_ERR) chk("tx_err", e, e_seen);
		n_last = n_seen;
	endtask : wtx
	task init(input logic [2:0] bd);
		chk("ref_freq", 24'hE10000, ref_freq_o);
		chk("power_save", 0, power_save_o);
		chk("sleep_mode", 0, sleep_mode_o);
		chk("sleep_timer", 0, sleep_timer_o);
		chk("char_timeout", 0, char_timeout_o);
		chk("doppler", 24'h000168, doppler_range_o);
		chk("flow_point", 0, flow_point_o);
		chk("counters", 0, {sat_done_o, sat_total_o, fix_count_o | fix_total_o});
		chk("rf_ctrl", 0, {rf_power_o, frequency_calibration_o, transmit_activity_ctrl_o});
		chk("baud", bd, baud_code_o);
	endtask : init
	function automatic gpshc_tx_e bad_reply(input logic sv);
		return sv ? TX_NACK : TX_ERR;
	endfunction : bad_reply
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	// Run needs under 2000 cycles
	initial begin
		#(50 * 5000);
		err_count++;
		report_and_stop();
	end
	initial begin
		{rst_b_i, rx_valid_i, rx_last_i, rx_fmt_bad_i, rx_server_i, up_send_i, up_server_i} = '0;
		{pos_start_i, pos_sat_done_i, pos_fix_done_i, slow, nack, rx_byte_i, pos_sat_total_i} = '0;
		{n_last, err_count, samples_checked} = '0;
		void'($urandom(81788));
		cyc(8);
		rst_b_i = 1'b1;
		init(3'h2);
		// Random writes, server and local
		repeat (6) begin
			{s, slow, d} = 26'($urandom);
			pkt(CMD_REF_FREQ, 8'h00, d, s, 1'b0);
			chk("ref_freq", d, ref_freq_o);
			if (s) wtx(TX_ACK, ERR_NONE);
			pkt(CMD_DOPPLER, 8'h00, d, s, 1'b0);
			chk("doppler", d[15:0], doppler_range_o);
			if (s) wtx(TX_ACK, ERR_NONE);
		end
		pkt(CMD_BAUD, 8'h00, 24'h000005, 1'b0, 1'b0);
		pkt(CMD_FLOW_PT, EXT_FLOW_PT, 24'h0000A5, 1'b0, 1'b0);
		pkt(CMD_RF_POWER, 8'h00, 24'h000001, 1'b0, 1'b0);
		pkt(CMD_SLEEP, 8'h01, d, 1'b0, 1'b0);
		chk("set_group", {d[15:0], 8'hA5}, {sleep_timer_o[15:0], flow_point_o});
		chk("set_bits", 24'h7, {baud_code_o[1:0], rf_power_o, sleep_mode_o});
		pos_sat_total_i = 8'($urandom);
		pos_start_i = 1'b1;
		cyc(1);
		{pos_start_i, pos_sat_done_i, pos_fix_done_i} = 3'b011;
		cyc(1);
		{pos_sat_done_i, pos_fix_done_i} = 2'b00;
		chk("counters", {pos_sat_total_i, 16'h0101}, {sat_total_o, sat_done_o, fix_count_o});
		// Format and undefined-id errors, both kinds
		for (int i = 0; i < 4; i++) begin
			pkt(i[1] ? 8'h99 : CMD_REF_FREQ, 8'h00, 24'h123456, i[0], !i[1]);
			wtx(bad_reply(i[0]), i[1] ? ERR_UNDEF : ERR_FORMAT);
			chk("ref_kept", d, ref_freq_o);
		end
		// 1 ms timeout, then a packet cut after one byte
		pkt(CMD_CHAR_TMO, 8'h00, 24'h000001, 1'b1, 1'b0);
		wtx(TX_ACK, ERR_NONE);
		{rx_valid_i, rx_byte_i} = {1'b1, CMD_POWER};
		cyc(1);
		rx_valid_i = 1'b0;
		wtx(TX_ERR, ERR_TIMEOUT);
		pkt(CMD_POWER, 8'h00, 24'h000003, 1'b0, 1'b0);
		chk("power_save", 3, power_save_o);
		chk("extension_identifier", 0, extension_identifier_o);
		pkt(CMD_RESET, 8'h00, 24'h000000, 1'b1, 1'b0);
		wtx(TX_ACK, ERR_NONE);
		init(3'h5);
		// Server uplink NACKed once, then ACKed
		{slow, nack, up_server_i, up_send_i} = 4'hF;
		cyc(1);
		up_send_i = 1'b0;
		wtx(TX_DATA, ERR_NONE);
		nack = 1'b0;
		chk("up_ready", 0, up_ready_o);
		wtx(TX_DATA, ERR_NONE);
		cyc(4);
		chk("up_ready", 1, up_ready_o);
		// Local uplink: host NACK causes no resend
		{nack, up_server_i, up_send_i} = 3'b101;
		cyc(1);
		up_send_i = 1'b0;
		wtx(TX_DATA, ERR_NONE);
		cyc(20);
		chk("tx_count", n_last, n_seen);
		chk("up_ready", 1, up_ready_o);
		report_and_stop();
	end
endmodule : gpshc_host_ctrl_tb
bind gpshc_host_ctrl gpshc_host_ctrl_asserts gpshc_host_ctrl_asserts_i (.*);
`default_nettype wire

// ### sim/gpshc_host_model.sv
// Purpose: Host stand-in: takes transmit requests, answers uplink data.
// Assumes: Host answers uplink data one cycle after its take.
// Notes:   Slow mode stalls every take by three cycles.
`timescale 1ns/100ps
`default_nettype none
module gpshc_host_model import gpshc_pkg::*; (
	input wire logic core_clk_i, rst_b_i, tx_req_o, slow_i, nack_i,
	input wire gpshc_tx_e tx_kind_o,
	input wire gpshc_err_e tx_err_o,
	output logic tx_taken_i, host_ack_i, host_nack_i,
	output gpshc_tx_e seen_kind_o,
	output gpshc_err_e seen_err_o,
	output logic [7:0] seen_n_o
);
	logic [1:0] wait_reg;
	logic rep_reg, rnack_reg;
	// NACK choice is latched at the take
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{tx_taken_i, host_ack_i, host_nack_i, rep_reg, rnack_reg, wait_reg, seen_n_o} <= '0;
			seen_kind_o <= TX_ACK;
			seen_err_o <= ERR_NONE;
		end else begin
			{tx_taken_i, host_ack_i, host_nack_i} <= 3'h0;
			if (rep_reg) begin
				host_nack_i <= rnack_reg;
				host_ack_i <= !rnack_reg;
				rep_reg <= 1'b0;
			end
			if (tx_req_o && !tx_taken_i) begin
				if (slow_i && wait_reg != 2'h3) wait_reg <= wait_reg + 2'h1;
				else begin
					tx_taken_i <= 1'b1;
					wait_reg <= 2'h0;
					seen_kind_o <= tx_kind_o;
					seen_err_o <= tx_err_o;
					seen_n_o <= seen_n_o + 8'h01;
					rep_reg <= tx_kind_o == TX_DATA;
					rnack_reg <= nack_i;
				end
			end
		end
	end
endmodule : gpshc_host_model
`default_nettype wire

// ### src/gpshc_char_timer.sv
// Purpose: Character timeout timer, counts whole milliseconds between received bytes.
// Assumes: Caller holds run_i high only while a packet is partly received.
// Notes:   A limit of zero never expires.
`timescale 1ns/100ps
`default_nettype none

module gpshc_char_timer
	import gpshc_pkg::*;
#(
	parameter int unsigned MS_CYC = MS_CYCLES_DFLT
)(
	input  wire logic             core_clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             run_i,
	input  wire logic             kick_i,
	input  wire logic [PRM_W-1:0] limit_ms_i,
	output logic                  expire_o
);

	localparam int unsigned PRE_W = $clog2(MS_CYC + 1);

	logic [PRE_W-1:0] pre_reg,    pre_next;
	logic [PRM_W-1:0] ms_reg,     ms_next;
	logic             expire_reg, expire_next;

	// Millisecond prescaler, then compare with the limit
	always_comb begin
		pre_next    = pre_reg;
		ms_next     = ms_reg;
		expire_next = 1'b0;
		if (!run_i || kick_i || limit_ms_i == TMO_INIT) begin
			pre_next = '0;
			ms_next  = '0;
		end else if (pre_reg == PRE_W'(MS_CYC - 1)) begin
			pre_next = '0;
			ms_next  = ms_reg + 1'b1;
			if (ms_next == limit_ms_i) begin
				expire_next = 1'b1;
				ms_next     = '0;
			end
		end else begin
			pre_next = pre_reg + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_reg    <= '0;
			ms_reg     <= '0;
			expire_reg <= 1'b0;
		end else begin
			pre_reg    <= pre_next;
			ms_reg     <= ms_next;
			expire_reg <= expire_next;
		end
	end

	assign expire_o = expire_reg;

endmodule : gpshc_char_timer

`default_nettype wire

// ### src/gpshc_host_ctrl.sv
// Purpose: Host command interpreter: parameter store, software reset, error control.
// Assumes: Bytes arrive from a serial framer on core_clk_i (8N1, 2400..115200 bps).
// Notes:   Byte 0 command, byte 1 extension, then up to 3 data bytes.
`timescale 1ns/100ps
`default_nettype none

module gpshc_host_ctrl
	import gpshc_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT,
	parameter int unsigned FLOW_W    = FLOW_W_DFLT
)(
	input  wire logic              core_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              rx_valid_i,
	input  wire logic [7:0]        rx_byte_i,
	input  wire logic              rx_last_i,
	input  wire logic              rx_fmt_bad_i,
	input  wire logic              rx_server_i,
	input  wire logic              host_ack_i,
	input  wire logic              host_nack_i,
	input  wire logic              up_send_i,
	input  wire logic              up_server_i,
	input  wire logic              tx_taken_i,
	input  wire logic              pos_start_i,
	input  wire logic [CNT_W-1:0]  pos_sat_total_i,
	input  wire logic              pos_sat_done_i,
	input  wire logic              pos_fix_done_i,
	output logic                   up_ready_o,
	output logic                   tx_req_o,
	output gpshc_tx_e              tx_kind_o,
	output gpshc_err_e             tx_err_o,
	output logic                   tx_resend_o,
	output logic                   cmd_exec_o,
	output logic [7:0]             command_identifier_o,
	output logic [7:0]             extension_identifier_o,
	output logic [2:0]             baud_code_o,
	output logic [PRM_W-1:0]       ref_freq_o,
	output logic [7:0]             power_save_o,
	output logic                   rf_power_o,
	output logic                   frequency_calibration_o,
	output logic                   transmit_activity_ctrl_o,
	output logic                   sleep_mode_o,
	output logic [PRM_W-1:0]       sleep_timer_o,
	output logic [PRM_W-1:0]       char_timeout_o,
	output logic [DOP_W-1:0]       doppler_range_o,
	output logic [FLOW_W-1:0]      flow_point_o,
	output logic [CNT_W-1:0]       sat_done_o,
	output logic [CNT_W-1:0]       sat_total_o,
	output logic [CNT_W-1:0]       fix_count_o,
	output logic [CNT_W-1:0]       fix_total_o
);

	// Identifiers the interpreter knows; anything else is undefined
	function automatic logic cmd_known(input logic [7:0] id);
		unique case (id)
			CMD_BAUD, CMD_REF_FREQ, CMD_POWER, CMD_RESET, CMD_RF_POWER,
			CMD_FREQ_CAL, CMD_TX_ACT, CMD_SLEEP, CMD_CHAR_TMO, CMD_CB_REQ,
			CMD_IA_REQ, CMD_SNAP, CMD_STATUS, CMD_VERSION, CMD_PROC_STAT,
			CMD_REST_PROC, CMD_ERR_STAT, CMD_CA_SET, CMD_CB_SET, CMD_DOPPLER,
			CMD_FLOW_PT: cmd_known = 1'b1;
			default:     cmd_known = 1'b0;
		endcase
	endfunction : cmd_known

	gpshc_rx_e        rx_st_reg,  rx_st_next;
	logic [7:0]       cmd_reg,    cmd_next;
	logic [7:0]       ext_reg,    ext_next;
	logic [PRM_W-1:0] data_reg,   data_next;
	logic             exec_reg,   exec_next;
	logic [2:0]       baud_reg,   baud_next;
	logic [PRM_W-1:0] ref_reg,    ref_next;
	logic [7:0]       psave_reg,  psave_next;
	logic             rf_reg,     rf_next;
	logic             fcal_reg,   fcal_next;
	logic             txa_reg,    txa_next;
	logic             smode_reg,  smode_next;
	logic [PRM_W-1:0] stime_reg,  stime_next;
	logic [PRM_W-1:0] ctmo_reg,   ctmo_next;
	logic [DOP_W-1:0] dop_reg,    dop_next;
	logic [FLOW_W-1:0] flow_reg,  flow_next;
	logic [CNT_W-1:0] sdone_reg,  sdone_next;
	logic [CNT_W-1:0] stot_reg,   stot_next;
	logic [CNT_W-1:0] fcnt_reg,   fcnt_next;
	logic [CNT_W-1:0] ftot_reg,   ftot_next;
	logic             rep_req;
	gpshc_tx_e        rep_kind;
	gpshc_err_e       rep_err;
	logic             tmo_fire;
	logic [7:0]       cmd_cur;
	logic [7:0]       ext_cur;
	logic [PRM_W-1:0] data_cur;
	gpshc_err_e       pkt_err;

	// Packet in progress feeds the timeout timer; each byte restarts it
	gpshc_char_timer #(
		.MS_CYC     (MS_CYCLES)
	) u_timer (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.run_i      (rx_st_reg != RX_IDLE),
		.kick_i     (rx_valid_i),
		.limit_ms_i (ctmo_reg),
		.expire_o   (tmo_fire)
	);

	gpshc_tx_sched u_sched (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.rep_req_i   (rep_req),
		.rep_kind_i  (rep_kind),
		.rep_err_i   (rep_err),
		.up_send_i   (up_send_i),
		.up_server_i (up_server_i),
		.host_ack_i  (host_ack_i),
		.host_nack_i (host_nack_i),
		.tx_taken_i  (tx_taken_i),
		.tx_req_o    (tx_req_o),
		.tx_kind_o   (tx_kind_o),
		.tx_err_o    (tx_err_o),
		.tx_resend_o (tx_resend_o),
		.up_ready_o  (up_ready_o)
	);

	// View of the packet including the byte arriving now
	always_comb begin
		cmd_cur  = (rx_st_reg == RX_IDLE) ? rx_byte_i : cmd_reg;
		ext_cur  = (rx_st_reg == RX_EXT) ? rx_byte_i : ext_reg;
		data_cur = (rx_st_reg == RX_DATA) ? {data_reg[PRM_W-9:0], rx_byte_i} : data_reg;
		if (rx_fmt_bad_i) begin
			pkt_err = ERR_FORMAT;
		end else if (!cmd_known(cmd_cur)) begin
			pkt_err = ERR_UNDEF;
		end else begin
			pkt_err = ERR_NONE;
		end
	end

	// Receive sequencing, error replies and command execution
	always_comb begin
		rx_st_next = rx_st_reg;
		cmd_next   = cmd_reg;
		ext_next   = ext_reg;
		data_next  = data_reg;
		exec_next  = 1'b0;
		rep_req    = 1'b0;
		rep_kind   = TX_ACK;
		rep_err    = ERR_NONE;
		baud_next  = baud_reg;
		ref_next   = ref_reg;
		psave_next = psave_reg;
		rf_next    = rf_reg;
		fcal_next  = fcal_reg;
		txa_next   = txa_reg;
		smode_next = smode_reg;
		stime_next = stime_reg;
		ctmo_next  = ctmo_reg;
		dop_next   = dop_reg;
		flow_next  = flow_reg;
		sdone_next = sdone_reg;
		stot_next  = stot_reg;
		fcnt_next  = fcnt_reg;
		ftot_next  = ftot_reg;
		// Counters follow the positioning engine
		if (pos_start_i) begin
			sdone_next = '0;
			stot_next  = pos_sat_total_i;
		end else if (pos_sat_done_i) begin
			sdone_next = sdone_reg + 1'b1;
		end
		if (pos_fix_done_i) begin
			fcnt_next = fcnt_reg + 1'b1;
			ftot_next = ftot_reg + 1'b1;
		end
		if (tmo_fire && !rx_valid_i) begin
			rx_st_next = RX_IDLE; // Partial packet is dropped
			data_next  = '0;
			rep_req    = 1'b1;
			rep_kind   = TX_ERR;
			rep_err    = ERR_TIMEOUT;
		end else if (rx_valid_i) begin
			cmd_next  = cmd_cur;
			ext_next  = ext_cur;
			data_next = data_cur;
			unique case (rx_st_reg)
				RX_IDLE: rx_st_next = RX_EXT;
				RX_EXT:  rx_st_next = RX_DATA;
				RX_DATA: rx_st_next = RX_DATA;
				default: rx_st_next = RX_IDLE;
			endcase
			if (rx_st_reg == RX_IDLE) begin
				ext_next  = BYTE_ZERO;
				data_next = '0;
			end
			if (rx_last_i) begin
				rx_st_next = RX_IDLE;
				if (pkt_err != ERR_NONE) begin
					// One error type per packet
					rep_req  = 1'b1; // Nothing executes for a bad packet
					rep_kind = rx_server_i ? TX_NACK : TX_ERR;
					rep_err  = pkt_err;
				end else begin
					exec_next = 1'b1;
					rep_req   = rx_server_i; // Local commands answer elsewhere
					rep_kind  = TX_ACK;
					unique case (cmd_cur)
						CMD_BAUD:     baud_next  = data_cur[2:0];
						CMD_REF_FREQ: ref_next   = data_cur;
						CMD_POWER:    psave_next = data_cur[7:0];
						CMD_RF_POWER: rf_next    = data_cur[0];
						CMD_FREQ_CAL: fcal_next  = data_cur[0];
						CMD_TX_ACT:   txa_next   = data_cur[0];
						CMD_CHAR_TMO: ctmo_next  = data_cur;
						CMD_DOPPLER:  dop_next   = data_cur[DOP_W-1:0];
						CMD_SLEEP: begin
							smode_next = ext_cur[0];
							stime_next = data_cur;
						end
						CMD_FLOW_PT: begin
							if (ext_cur == EXT_FLOW_PT) begin
								flow_next = data_cur[FLOW_W-1:0];
							end
						end
						CMD_RESET: begin
							// Power-on values, baud rate kept
							ref_next   = REF_FREQ_INIT;
							psave_next = BYTE_ZERO;
							rf_next    = 1'b0;
							fcal_next  = 1'b0;
							txa_next   = 1'b0;
							smode_next = 1'b0;
							stime_next = TMO_INIT;
							ctmo_next  = TMO_INIT;
							dop_next   = DOPPLER_INIT;
							flow_next  = '0;
							sdone_next = '0;
							stot_next  = '0;
							fcnt_next  = '0;
							ftot_next  = '0;
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// Power-on values match the software reset values above
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_st_reg <= RX_IDLE;
			cmd_reg   <= BYTE_ZERO;
			ext_reg   <= BYTE_ZERO;
			data_reg  <= '0;
			exec_reg  <= 1'b0;
			baud_reg  <= BAUD_INIT;
			ref_reg   <= REF_FREQ_INIT;
			psave_reg <= BYTE_ZERO;
			rf_reg    <= 1'b0;
			fcal_reg  <= 1'b0;
			txa_reg   <= 1'b0;
			smode_reg <= 1'b0;
			stime_reg <= TMO_INIT;
			ctmo_reg  <= TMO_INIT;
			dop_reg   <= DOPPLER_INIT;
			flow_reg  <= '0;
			sdone_reg <= '0;
			stot_reg  <= '0;
			fcnt_reg  <= '0;
			ftot_reg  <= '0;
		end else begin
			rx_st_reg <= rx_st_next;
			cmd_reg   <= cmd_next;
			ext_reg   <= ext_next;
			data_reg  <= data_next;
			exec_reg  <= exec_next;
			baud_reg  <= baud_next;
			ref_reg   <= ref_next;
			psave_reg <= psave_next;
			rf_reg    <= rf_next;
			fcal_reg  <= fcal_next;
			txa_reg   <= txa_next;
			smode_reg <= smode_next;
			stime_reg <= stime_next;
			ctmo_reg  <= ctmo_next;
			dop_reg   <= dop_next;
			flow_reg  <= flow_next;
			sdone_reg <= sdone_next;
			stot_reg  <= stot_next;
			fcnt_reg  <= fcnt_next;
			ftot_reg  <= ftot_next;
		end
	end

	// Outputs straight from the state flops
	assign cmd_exec_o               = exec_reg;
	assign command_identifier_o     = cmd_reg;
	assign extension_identifier_o   = ext_reg;
	assign baud_code_o              = baud_reg;
	assign ref_freq_o               = ref_reg;
	assign power_save_o             = psave_reg;
	assign rf_power_o               = rf_reg;
	assign frequency_calibration_o  = fcal_reg;
	assign transmit_activity_ctrl_o = txa_reg;
	assign sleep_mode_o             = smode_reg;
	assign sleep_timer_o            = stime_reg;
	assign char_timeout_o           = ctmo_reg;
	assign doppler_range_o          = dop_reg;
	assign flow_point_o             = flow_reg;
	assign sat_done_o               = sdone_reg;
	assign sat_total_o              = stot_reg;
	assign fix_count_o              = fcnt_reg;
	assign fix_total_o              = ftot_reg;

endmodule : gpshc_host_ctrl

`default_nettype wire

// ### src/gpshc_pkg.sv
// Purpose: Shared constants and types of the host command and error control block.
// Assumes: 20 MHz core clock; bytes framed by a neighbouring receiver.
// Notes:   Error codes and byte layout are local choices.
package gpshc_pkg;

	// Command identifiers
	localparam logic [7:0] CMD_BAUD      = 8'h01;
	localparam logic [7:0] CMD_REF_FREQ  = 8'h02;
	localparam logic [7:0] CMD_POWER     = 8'h03;
	localparam logic [7:0] CMD_RESET     = 8'h04;
	localparam logic [7:0] CMD_RF_POWER  = 8'h05;
	localparam logic [7:0] CMD_FREQ_CAL  = 8'h06;
	localparam logic [7:0] CMD_TX_ACT    = 8'h07;
	localparam logic [7:0] CMD_SLEEP     = 8'h12;
	localparam logic [7:0] CMD_CHAR_TMO  = 8'h13;
	localparam logic [7:0] CMD_CB_REQ    = 8'h20;
	localparam logic [7:0] CMD_IA_REQ    = 8'h21;
	localparam logic [7:0] CMD_SNAP      = 8'h2D;
	localparam logic [7:0] CMD_STATUS    = 8'h30;
	localparam logic [7:0] CMD_VERSION   = 8'h31;
	localparam logic [7:0] CMD_PROC_STAT = 8'h33;
	localparam logic [7:0] CMD_REST_PROC = 8'h34;
	localparam logic [7:0] CMD_ERR_STAT  = 8'h3F;
	localparam logic [7:0] CMD_CA_SET    = 8'h40;
	localparam logic [7:0] CMD_CB_SET    = 8'h41;
	localparam logic [7:0] CMD_DOPPLER   = 8'h57;
	localparam logic [7:0] CMD_FLOW_PT   = 8'h7F;
	localparam logic [7:0] EXT_FLOW_PT   = 8'h00;

	// Widths
	localparam int unsigned PRM_W       = 24;
	localparam int unsigned DOP_W       = 16;
	localparam int unsigned CNT_W       = 8;
	localparam int unsigned FLOW_W_DFLT = 8;

	// Power-on values
	localparam logic [2:0]       BAUD_INIT     = 3'h2;      // 9600 bps
	localparam logic [PRM_W-1:0] REF_FREQ_INIT = 24'hE10000; // 14.4 MHz x 1.024
	localparam logic [DOP_W-1:0] DOPPLER_INIT  = 16'h0168;   // 360 Hz
	localparam logic [PRM_W-1:0] TMO_INIT      = 24'h000000;
	localparam logic [7:0]       BYTE_ZERO     = 8'h00;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MS_PERIOD_NS  = 1000000;
	localparam int unsigned MS_CYCLES_DFLT = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ERR_NONE    = 2'h0,
		ERR_FORMAT  = 2'h1,
		ERR_TIMEOUT = 2'h2,
		ERR_UNDEF   = 2'h3
	} gpshc_err_e;

	typedef enum logic [1:0] {
		TX_ACK  = 2'h0,
		TX_NACK = 2'h1,
		TX_ERR  = 2'h2,
		TX_DATA = 2'h3
	} gpshc_tx_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_EXT  = 2'b01,
		RX_DATA = 2'b11
	} gpshc_rx_e;

endpackage : gpshc_pkg

// ### src/gpshc_tx_sched.sv
// Purpose: Orders outgoing replies and uplink packets, tracks host ACK/NACK.
// Assumes: tx_taken_i pulses when the framer accepts a request.
// Notes:   Replies go before uplink data; one reply is held, the latest wins.
`timescale 1ns/100ps
`default_nettype none

module gpshc_tx_sched
	import gpshc_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       rep_req_i,
	input  wire gpshc_tx_e  rep_kind_i,
	input  wire gpshc_err_e rep_err_i,
	input  wire logic       up_send_i,
	input  wire logic       up_server_i,
	input  wire logic       host_ack_i,
	input  wire logic       host_nack_i,
	input  wire logic       tx_taken_i,
	output logic            tx_req_o,
	output gpshc_tx_e       tx_kind_o,
	output gpshc_err_e      tx_err_o,
	output logic            tx_resend_o,
	output logic            up_ready_o
);

	logic       rep_pend_reg, rep_pend_next;
	gpshc_tx_e  rep_kind_reg, rep_kind_next;
	gpshc_err_e rep_err_reg,  rep_err_next;
	logic       dat_pend_reg, dat_pend_next;
	logic       dat_srv_reg,  dat_srv_next;
	logic       resend_reg,   resend_next;
	logic       await_reg,    await_next;
	logic       tx_req_reg,   tx_req_next;
	gpshc_tx_e  tx_kind_reg,  tx_kind_next;
	gpshc_err_e tx_err_reg,   tx_err_next;
	logic       tx_rs_reg,    tx_rs_next;
	logic       ready_reg,    ready_next;

	// Issue first, then take new events, so an event never loses to a clear
	always_comb begin
		rep_pend_next = rep_pend_reg;
		rep_kind_next = rep_kind_reg;
		rep_err_next  = rep_err_reg;
		dat_pend_next = dat_pend_reg;
		dat_srv_next  = dat_srv_reg;
		resend_next   = resend_reg;
		await_next    = await_reg;
		tx_req_next   = tx_req_reg;
		tx_kind_next  = tx_kind_reg;
		tx_err_next   = tx_err_reg;
		tx_rs_next    = tx_rs_reg;
		if (tx_req_reg && tx_taken_i) begin
			tx_req_next = 1'b0;
		end
		if (!tx_req_reg) begin
			if (rep_pend_reg) begin
				tx_req_next   = 1'b1;
				tx_kind_next  = rep_kind_reg;
				tx_err_next   = rep_err_reg;
				tx_rs_next    = 1'b0;
				rep_pend_next = 1'b0;
			end else if (dat_pend_reg) begin
				tx_req_next   = 1'b1;
				tx_kind_next  = TX_DATA;
				tx_err_next   = ERR_NONE;
				tx_rs_next    = resend_reg;
				dat_pend_next = 1'b0;
				await_next    = dat_srv_reg; // Local packets expect no ACK
			end
		end
		if (rep_req_i) begin
			rep_pend_next = 1'b1;
			rep_kind_next = rep_kind_i;
			rep_err_next  = rep_err_i;
		end
		if (up_send_i && ready_reg) begin
			dat_pend_next = 1'b1;
			dat_srv_next  = up_server_i;
			resend_next   = 1'b0;
		end
		// NACK with nothing awaited is dropped
		if (await_reg && host_ack_i) begin
			await_next = 1'b0;
		end else if (await_reg && host_nack_i) begin
			await_next    = 1'b0;
			dat_pend_next = 1'b1; // Same packet again
			resend_next   = 1'b1;
		end
		ready_next = !(dat_pend_next || await_next);
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rep_pend_reg <= 1'b0;
			rep_kind_reg <= TX_ACK;
			rep_err_reg  <= ERR_NONE;
			dat_pend_reg <= 1'b0;
			dat_srv_reg  <= 1'b0;
			resend_reg   <= 1'b0;
			await_reg    <= 1'b0;
			tx_req_reg   <= 1'b0;
			tx_kind_reg  <= TX_ACK;
			tx_err_reg   <= ERR_NONE;
			tx_rs_reg    <= 1'b0;
			ready_reg    <= 1'b1;
		end else begin
			rep_pend_reg <= rep_pend_next;
			rep_kind_reg <= rep_kind_next;
			rep_err_reg  <= rep_err_next;
			dat_pend_reg <= dat_pend_next;
			dat_srv_reg  <= dat_srv_next;
			resend_reg   <= resend_next;
			await_reg    <= await_next;
			tx_req_reg   <= tx_req_next;
			tx_kind_reg  <= tx_kind_next;
			tx_err_reg   <= tx_err_next;
			tx_rs_reg    <= tx_rs_next;
			ready_reg    <= ready_next;
		end
	end

	assign tx_req_o    = tx_req_reg;
	assign tx_kind_o   = tx_kind_reg;
	assign tx_err_o    = tx_err_reg;
	assign tx_resend_o = tx_rs_reg;
	assign up_ready_o  = ready_reg;

endmodule : gpshc_tx_sched

`default_nettype wire
